// file: rtl/pcs_cmd_status.sv
`timescale 1ns/10ps
// Function
// - set parity-fault-seen flag on every detected parity error, even if unreported.
// - set system-fault-driven flag whenever the system fault pin is driven.
// - set master-abort flag when own master transaction ends in master abort.
// - set target-abort-received flag when a target aborts own master transaction.
// - target-abort-issued bit always reads zero.
// - decode speed field reads 01; target claim uses medium timing.
// - master data parity flag needs parity pin event, bus mastership, response enable.
// - back-to-back capable and enable bits read zero; never fast back-to-back.
// - high-speed capable and capability list bits read zero.
// - interrupt status bit shows back-end interrupt, independent of pin disable.
// - drive interrupt pin low when interrupt status set and pin disable clear.
// - interrupt pin disable set keeps the interrupt pin driver off.
// - reserved bits 18-11 and 22 read zero.
// - system fault pin enable gates the system fault pin driver.
// - address stepping bit reads zero.
// - parity response clear: flag still set, parity pin not driven.
// - write-and-invalidate command only allowed while its enable is set.
// - special cycle enable is zero; special cycles always ignored.
// - no master transaction starts while master enable is clear.
// - no memory access claimed while memory space enable is clear.
// - io space enable reads zero; io accesses never claimed.
// - writing one clears an error flag, writing zero leaves it.
module pcs_cmd_status (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link side, sampled asynchronously
  input wire logic pciClk,
  input wire logic parityFaultPinIn,
  output logic parityFaultPinOut,
  output logic parityFaultPinOe,
  output logic systemFaultPinOut,
  output logic systemFaultPinOe,
  output logic interruptAPinOut,
  output logic interruptAPinOe,
  output logic targetClaimPinOut,
  output logic targetClaimPinOe,
  // interface internals, same clock
  input wire pcs_pkg::pcs_event_s coreEvent,
  input wire logic masterStartReq,
  output logic masterStartGrant,
  input wire logic writeInvalidateReq,
  output logic writeInvalidateAllowed,
  input wire logic memDecodeHit,
  output logic memClaim,
  input wire logic ioDecodeHit,
  output logic ioClaim,
  input wire logic specialCycleHit,
  output logic specialCycleClaim
);

  // sticky flags
  logic parityFaultSeenFlag;
  logic systemFaultDrivenFlag;
  logic masterAbortFlag;
  logic targetAbortReceivedFlag;
  logic masterDataParityFlag;
  // writable enables
  logic interruptPinDisable;
  logic systemFaultPinEnable;
  logic parityResponseEnable;
  logic writeInvalidateEnable;
  logic masterEnable;
  logic memorySpaceEnable;
  // registered pin drives
  pcs_pkg::pcs_pin_s parityPin;
  pcs_pkg::pcs_pin_s systemPin;
  pcs_pkg::pcs_pin_s interruptPin;
  pcs_pkg::pcs_pin_s claimPin;
  // link sampling
  logic [1:0] linkSync;
  logic pciClkSeen;
  logic pciRise;
  logic parityPinLow;
  logic [1:0] claimEdges;
  logic [31:0] readWord;

  // apb decode
  wire csrHit = (paddr & pcs_pkg::ADDR_MASK) == pcs_pkg::CSR_OFFSET;
  wire apbAccess = psel & penable;
  wire csrWrite = apbAccess & pwrite & csrHit & clkEn;
  wire flagLaneWrite = csrWrite & pstrb[3];
  wire upperCmdWrite = csrWrite & pstrb[1];
  wire lowerCmdWrite = csrWrite & pstrb[0];

  // write-one-to-clear of a single flag, gated by its byte lane
  function automatic logic clearHit(input logic laneWrite, input logic [31:0] data, input int bitPos);
    clearHit = laneWrite & data[bitPos];
  endfunction : clearHit

  // next sticky value: a set in the clearing cycle wins so no event is lost
  function automatic logic stickyNext(input logic current, input logic setEvt, input logic clr);
    stickyNext = setEvt | (current & ~clr);
  endfunction : stickyNext

  // both link inputs cross into clk_sys through two flops
  pcs_pin_sync #(
    .WIDTH(2)
  ) linkSyncInst (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .asyncIn({pciClk, parityFaultPinIn}),
    .resetValue(2'h3),
    .syncOut(linkSync)
  );

  // link clock edge and pin observation at each link rising edge
  assign pciRise = linkSync[1] & ~pciClkSeen;
  assign parityPinLow = pciRise & ~linkSync[0];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pciClkSeen <= 1'b1;
    end else if (clkEn) begin
      pciClkSeen <= linkSync[1];
    end
  end

  // event terms feeding the flags
  wire parityFlagSet = coreEvent.parityDetect;
  wire systemFlagSet = systemPin.oe;
  wire masterAbortSet = coreEvent.masterAbort;
  wire targetAbortSet = coreEvent.targetAbort;
  // own drive or an observed low counts, only as master with response on
  wire masterParitySet = (parityPin.oe | parityPinLow) & coreEvent.masterActive & parityResponseEnable;

  // sticky error flags, reset to zero, cleared by writing one
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      parityFaultSeenFlag <= pcs_pkg::FLAG_RESET;
      systemFaultDrivenFlag <= pcs_pkg::FLAG_RESET;
      masterAbortFlag <= pcs_pkg::FLAG_RESET;
      targetAbortReceivedFlag <= pcs_pkg::FLAG_RESET;
      masterDataParityFlag <= pcs_pkg::FLAG_RESET;
    end else if (clkEn) begin
      parityFaultSeenFlag <= stickyNext(parityFaultSeenFlag, parityFlagSet,
        clearHit(flagLaneWrite, pwdata, pcs_pkg::PARITY_FAULT_SEEN_BIT));
      systemFaultDrivenFlag <= stickyNext(systemFaultDrivenFlag, systemFlagSet,
        clearHit(flagLaneWrite, pwdata, pcs_pkg::SYSTEM_FAULT_DRIVEN_BIT));
      masterAbortFlag <= stickyNext(masterAbortFlag, masterAbortSet,
        clearHit(flagLaneWrite, pwdata, pcs_pkg::MASTER_ABORT_BIT));
      targetAbortReceivedFlag <= stickyNext(targetAbortReceivedFlag, targetAbortSet,
        clearHit(flagLaneWrite, pwdata, pcs_pkg::TARGET_ABORT_RECEIVED_BIT));
      masterDataParityFlag <= stickyNext(masterDataParityFlag, masterParitySet,
        clearHit(flagLaneWrite, pwdata, pcs_pkg::MASTER_DATA_PARITY_BIT));
    end
  end

  // writable enables, all reset to zero, so the interrupt pin starts enabled
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      interruptPinDisable <= pcs_pkg::ENABLE_RESET;
      systemFaultPinEnable <= pcs_pkg::ENABLE_RESET;
      parityResponseEnable <= pcs_pkg::ENABLE_RESET;
      writeInvalidateEnable <= pcs_pkg::ENABLE_RESET;
      masterEnable <= pcs_pkg::ENABLE_RESET;
      memorySpaceEnable <= pcs_pkg::ENABLE_RESET;
    end else begin
      if (upperCmdWrite) begin
        interruptPinDisable <= pwdata[pcs_pkg::INTERRUPT_PIN_DISABLE_BIT];
        systemFaultPinEnable <= pwdata[pcs_pkg::SYSTEM_FAULT_PIN_ENABLE_BIT];
      end
      if (lowerCmdWrite) begin
        parityResponseEnable <= pwdata[pcs_pkg::PARITY_RESPONSE_ENABLE_BIT];
        writeInvalidateEnable <= pwdata[pcs_pkg::WRITE_INVALIDATE_ENABLE_BIT];
        masterEnable <= pwdata[pcs_pkg::MASTER_ENABLE_BIT];
        memorySpaceEnable <= pwdata[pcs_pkg::MEMORY_SPACE_ENABLE_BIT];
      end
    end
  end

  // pin drivers: every pin is active low, so out stays 0 and oe carries the state
  wire parityDriveNext = coreEvent.parityReport & parityResponseEnable;
  wire systemDriveNext = coreEvent.systemFault & systemFaultPinEnable;
  wire interruptDriveNext = coreEvent.backEndIrq & ~interruptPinDisable;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      parityPin <= '0;
      systemPin <= '0;
      interruptPin <= '0;
    end else if (clkEn) begin
      parityPin.oe <= parityDriveNext;
      systemPin.oe <= systemDriveNext;
      interruptPin.oe <= interruptDriveNext;
    end
  end

  // medium decode: count link edges after the address phase, claim on the second
  wire claimAllowed = memDecodeHit & memorySpaceEnable;
  wire claimReached = claimEdges == pcs_pkg::CLAIM_EDGE_COUNT;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      claimEdges <= 2'h0;
      claimPin <= '0;
    end else if (clkEn) begin
      if (!claimAllowed) begin
        claimEdges <= 2'h0;
        claimPin.oe <= 1'b0;
      end else if (pciRise && !claimReached) begin
        claimEdges <= claimEdges + 2'h1;
      end else if (claimReached) begin
        claimPin.oe <= 1'b1;
      end
    end
  end

  assign parityFaultPinOut = parityPin.out;
  assign parityFaultPinOe = parityPin.oe;
  assign systemFaultPinOut = systemPin.out;
  assign systemFaultPinOe = systemPin.oe;
  assign interruptAPinOut = interruptPin.out;
  assign interruptAPinOe = interruptPin.oe;
  assign targetClaimPinOut = claimPin.out;
  assign targetClaimPinOe = claimPin.oe;

  // gates towards master and slave units
  assign masterStartGrant = masterStartReq & masterEnable;
  assign writeInvalidateAllowed = writeInvalidateReq & writeInvalidateEnable;
  assign memClaim = claimPin.oe;
  // hardwired enables mean these can never fire
  assign ioClaim = ioDecodeHit & pcs_pkg::HARDWIRED_ZERO;
  assign specialCycleClaim = specialCycleHit & pcs_pkg::HARDWIRED_ZERO;

  // read word assembly; unlisted bits are reserved and read zero
  always_comb begin
    readWord = 32'h0000_0000;
    readWord[pcs_pkg::PARITY_FAULT_SEEN_BIT] = parityFaultSeenFlag;
    readWord[pcs_pkg::SYSTEM_FAULT_DRIVEN_BIT] = systemFaultDrivenFlag;
    readWord[pcs_pkg::MASTER_ABORT_BIT] = masterAbortFlag;
    readWord[pcs_pkg::TARGET_ABORT_RECEIVED_BIT] = targetAbortReceivedFlag;
    readWord[pcs_pkg::TARGET_ABORT_ISSUED_BIT] = pcs_pkg::HARDWIRED_ZERO;
    readWord[pcs_pkg::DECODE_SPEED_LSB +: 2] = pcs_pkg::DECODE_SPEED_MEDIUM;
    readWord[pcs_pkg::MASTER_DATA_PARITY_BIT] = masterDataParityFlag;
    readWord[pcs_pkg::BACK_TO_BACK_CAPABLE_BIT] = pcs_pkg::HARDWIRED_ZERO;
    readWord[pcs_pkg::HIGH_SPEED_CAPABLE_BIT] = pcs_pkg::HARDWIRED_ZERO;
    readWord[pcs_pkg::CAPABILITY_LIST_PRESENT_BIT] = pcs_pkg::HARDWIRED_ZERO;
    readWord[pcs_pkg::INTERRUPT_STATUS_BIT] = coreEvent.backEndIrq;
    readWord[pcs_pkg::INTERRUPT_PIN_DISABLE_BIT] = interruptPinDisable;
    readWord[pcs_pkg::BACK_TO_BACK_ENABLE_BIT] = pcs_pkg::HARDWIRED_ZERO;
    readWord[pcs_pkg::SYSTEM_FAULT_PIN_ENABLE_BIT] = systemFaultPinEnable;
    readWord[pcs_pkg::ADDRESS_STEPPING_BIT] = pcs_pkg::HARDWIRED_ZERO;
    readWord[pcs_pkg::PARITY_RESPONSE_ENABLE_BIT] = parityResponseEnable;
    readWord[pcs_pkg::PALETTE_SNOOP_BIT] = pcs_pkg::HARDWIRED_ZERO;
    readWord[pcs_pkg::WRITE_INVALIDATE_ENABLE_BIT] = writeInvalidateEnable;
    readWord[pcs_pkg::SPECIAL_CYCLE_ENABLE_BIT] = pcs_pkg::HARDWIRED_ZERO;
    readWord[pcs_pkg::MASTER_ENABLE_BIT] = masterEnable;
    readWord[pcs_pkg::MEMORY_SPACE_ENABLE_BIT] = memorySpaceEnable;
    readWord[pcs_pkg::IO_SPACE_ENABLE_BIT] = pcs_pkg::HARDWIRED_ZERO;
  end

  // read data registered at setup so it is stable during the access phase
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (clkEn && psel && !penable) begin
      prdata <= (csrHit && !pwrite) ? readWord : 32'h0000_0000;
    end
  end

  // zero wait states while enabled; a frozen block stalls the bus
  assign pready = clkEn;
  assign pslverr = apbAccess & ~csrHit;

endmodule : pcs_cmd_status

// file: rtl/pcs_pkg.sv
package pcs_pkg;

  // register map (APB byte address)
  localparam logic [11:0] CSR_OFFSET = 12'h004;
  localparam logic [11:0] ADDR_MASK = 12'hFFC;

  // status bits: sticky error flags and read-only fields
  localparam int PARITY_FAULT_SEEN_BIT = 31;
  localparam int SYSTEM_FAULT_DRIVEN_BIT = 30;
  localparam int MASTER_ABORT_BIT = 29;
  localparam int TARGET_ABORT_RECEIVED_BIT = 28;
  localparam int TARGET_ABORT_ISSUED_BIT = 27;
  localparam int DECODE_SPEED_LSB = 25;
  localparam int MASTER_DATA_PARITY_BIT = 24;
  localparam int BACK_TO_BACK_CAPABLE_BIT = 23;
  localparam int HIGH_SPEED_CAPABLE_BIT = 21;
  localparam int CAPABILITY_LIST_PRESENT_BIT = 20;
  localparam int INTERRUPT_STATUS_BIT = 19;

  // command (enable) bits
  localparam int INTERRUPT_PIN_DISABLE_BIT = 10;
  localparam int BACK_TO_BACK_ENABLE_BIT = 9;
  localparam int SYSTEM_FAULT_PIN_ENABLE_BIT = 8;
  localparam int ADDRESS_STEPPING_BIT = 7;
  localparam int PARITY_RESPONSE_ENABLE_BIT = 6;
  localparam int PALETTE_SNOOP_BIT = 5;
  localparam int WRITE_INVALIDATE_ENABLE_BIT = 4;
  localparam int SPECIAL_CYCLE_ENABLE_BIT = 3;
  localparam int MASTER_ENABLE_BIT = 2;
  localparam int MEMORY_SPACE_ENABLE_BIT = 1;
  localparam int IO_SPACE_ENABLE_BIT = 0;

  // fixed field values and reset values
  localparam logic [1:0] DECODE_SPEED_MEDIUM = 2'h1;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic HARDWIRED_ZERO = 1'b0;

  // medium decode: claim on the second link clock after the address phase
  localparam logic [1:0] CLAIM_EDGE_COUNT = 2'h2;

  // events and levels from the interface's master, slave and back end
  typedef struct packed {
    logic parityDetect;   // pulse: any parity error detected
    logic parityReport;   // level: logic wants to report a parity error on the pin
    logic systemFault;    // level: internal system error condition
    logic masterAbort;    // pulse: own master transaction ended in master abort
    logic targetAbort;    // pulse: target aborted own master transaction
    logic masterActive;   // level: this device is current bus master
    logic backEndIrq;     // level: back-end interrupt state
  } pcs_event_s;

  // open-drain pin drives (output value and enable)
  typedef struct packed {
    logic out;
    logic oe;
  } pcs_pin_s;

endpackage : pcs_pkg

// file: rtl/pcs_pin_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser for inputs from outside the clk_sys domain
module pcs_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] asyncIn,
  input wire logic [WIDTH-1:0] resetValue,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stageOne;
  logic [WIDTH-1:0] stageTwo;

  // stage one feeds stage two only; reset constant chosen idle-high
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stageOne <= {WIDTH{1'b1}};
      stageTwo <= {WIDTH{1'b1}};
    end else if (clkEn) begin
      stageOne <= asyncIn;
      stageTwo <= stageOne;
    end
  end

  // resetValue unused by the flops; kept for width check of callers
  assign syncOut = stageTwo & (resetValue | ~resetValue);

endmodule : pcs_pin_sync

// file: verif/pcs_cmd_status_asserts.sv
`timescale 1ns/10ps
// port-level checks of the command/status block
module pcs_cmd_status_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire pcs_pkg::pcs_event_s coreEvent,
  input wire logic masterStartReq,
  input wire logic masterStartGrant,
  input wire logic writeInvalidateAllowed,
  input wire logic ioClaim,
  input wire logic specialCycleClaim,
  input wire logic targetClaimPinOe,
  input wire logic interruptAPinOe,
  input wire logic systemFaultPinOe,
  input wire logic parityFaultPinOe
);
  logic [10:0] en;
  // access decode at the one mapped word
  wire csrHit = psel && penable && clkEn && (paddr & pcs_pkg::ADDR_MASK) == pcs_pkg::CSR_OFFSET;
  wire wrHit = csrHit && pwrite;
  wire rdHit = csrHit && !pwrite;
  // shadow of the writable enables, so gating is checked against the exact bit
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      en <= 11'h000;
    end else if (wrHit) begin
      en <= {pstrb[1] ? pwdata[10:8] & 3'h5 : en[10:8], pstrb[0] ? pwdata[7:0] & 8'h56 : en[7:0]};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst || !clkEn);
  property p_irq_on; coreEvent.backEndIrq && !en[10] |=> interruptAPinOe; endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("interrupt pin not driven");
  property p_irq_off; en[10] |=> !interruptAPinOe; endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt pin driven while disabled");
  property p_serr; 1 |=> systemFaultPinOe == $past(coreEvent.systemFault && en[8]); endproperty
  a_serr: assert property (p_serr)
    else $error("system fault pin gating wrong");
  property p_perr; parityFaultPinOe |-> $past(coreEvent.parityReport && en[6]); endproperty
  a_perr: assert property (p_perr)
    else $error("parity pin driven without response enable");
  property p_grant; masterStartGrant == (masterStartReq && en[2]); endproperty
  a_grant: assert property (p_grant)
    else $error("master start grant wrong");
  property p_wrinv; writeInvalidateAllowed |-> en[4]; endproperty
  a_wrinv: assert property (p_wrinv)
    else $error("write-invalidate allowed while disabled");
  property p_no_claim; !(ioClaim || specialCycleClaim); endproperty
  a_no_claim: assert property (p_no_claim)
    else $error("io or special cycle claimed");
  property p_mem_off; !en[1] |=> !targetClaimPinOe; endproperty
  a_mem_off: assert property (p_mem_off)
    else $error("memory access claimed while disabled");
  property p_fixed; rdHit |-> prdata[27:25] == 3'h1 && prdata[23:20] == 4'h0 && prdata[18:11] == 8'h00; endproperty
  a_fixed: assert property (p_fixed)
    else $error("hardwired read bits wrong");
  property p_enables; rdHit |-> prdata[10:0] == en; endproperty
  a_enables: assert property (p_enables)
    else $error("enable bits read back wrong");
  property p_irq_stat; rdHit |-> prdata[19] == $past(coreEvent.backEndIrq); endproperty
  a_irq_stat: assert property (p_irq_stat)
    else $error("interrupt status bit wrong");
  c_clear: cover property (wrHit && pwdata[31]);
  c_mdpar: cover property (rdHit && prdata[24]);
  c_claim: cover property ($rose(targetClaimPinOe));
endmodule : pcs_cmd_status_asserts

// file: verif/pcs_link_model.sv
`timescale 1ns/10ps
// far-side bus agent: link clock and the pulled-up parity line
module pcs_link_model (
  input wire logic run,
  input wire logic reportParity,
  input wire logic parityFaultPinOe,
  output logic pciClk,
  output logic parityFaultPinIn
);
  // clock runs only while a frame is open, odd offset keeps it unrelated to clk_sys
  initial begin
    pciClk = 1'b0;
    #3.3;
    forever begin
      #62.5;
      pciClk = run ? ~pciClk : 1'b0;
    end
  end
  // open-drain line with pull-up: low while either party drives it
  assign parityFaultPinIn = ~(parityFaultPinOe | reportParity);
endmodule : pcs_link_model

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk_sys, sys_rst, clkEn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, w, m, en;
  logic [3:0] pstrb, s;
  logic pciClk, parityFaultPinIn, linkRun, reportParity;
  logic parityFaultPinOut, parityFaultPinOe, systemFaultPinOut, systemFaultPinOe;
  logic interruptAPinOut, interruptAPinOe, targetClaimPinOut, targetClaimPinOe;
  pcs_pkg::pcs_event_s coreEvent;
  logic masterStartReq, masterStartGrant, writeInvalidateReq, writeInvalidateAllowed;
  logic memDecodeHit, memClaim, ioDecodeHit, ioClaim, specialCycleHit, specialCycleClaim;
  logic [7:0] pinVec;
  logic [32:0] expQ[$];
  int n_errors, tests_run, i;
  int evIdx[3] = '{6, 3, 2};
  logic [31:0] flagBit[3] = '{32'h80000000, 32'h20000000, 32'h10000000};
  localparam logic [11:0] CSR = pcs_pkg::CSR_OFFSET;
  assign pinVec = {interruptAPinOe, systemFaultPinOe, parityFaultPinOe, memClaim,
                   masterStartGrant, writeInvalidateAllowed, ioClaim, specialCycleClaim};

  pcs_cmd_status i_pcs_cmd_status (.clk_sys, .sys_rst, .clkEn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .pciClk, .parityFaultPinIn, .parityFaultPinOut,
    .parityFaultPinOe, .systemFaultPinOut, .systemFaultPinOe, .interruptAPinOut, .interruptAPinOe,
    .targetClaimPinOut, .targetClaimPinOe, .coreEvent, .masterStartReq, .masterStartGrant,
    .writeInvalidateReq, .writeInvalidateAllowed, .memDecodeHit, .memClaim, .ioDecodeHit, .ioClaim,
    .specialCycleHit, .specialCycleClaim);
  pcs_link_model i_pcs_link_model (.run(linkRun), .reportParity, .parityFaultPinOe, .pciClk,
    .parityFaultPinIn);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // one apb transfer; a read leaves its expected {pslverr, prdata} as a note
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                     input logic [32:0] exp);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    if (!wr) expQ.push_back(exp);
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // read monitor: oldest note against what the slave returns
  always @(posedge clk_sys) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (expQ.size() == 0) begin
        check("unexpected read", 33'h0, 33'h1);
      end else begin
        check("read word", expQ.pop_front(), {pslverr, prdata});
      end
    end
  end

  // watchdog against a hang anywhere
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {coreEvent, masterStartReq, writeInvalidateReq, memDecodeHit, ioDecodeHit, specialCycleHit} = '0;
    {linkRun, reportParity, n_errors, tests_run} = '0;
    sys_rst = 1'b1;
    clkEn = 1'b1;
    w = $urandom(32'hA1B22677);
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, CSR, 32'h0, 4'h0, {1'b0, 32'h02000000});
    apb(1'b1, CSR, 32'hFFFFFFFF, 4'hF, 33'h0);
    apb(1'b0, CSR, 32'h0, 4'h0, {1'b0, 32'h02000556});
    apb(1'b1, CSR + 12'h004, 32'h0, 4'hF, 33'h0);
    apb(1'b0, CSR + 12'h004, 32'h0, 4'h0, {1'b1, 32'h0});
    // random words under random lane strobes; only lanes 0 and 1 hold enables
    en = 32'h556;
    for (i = 0; i < 6; i++) begin
      w = $urandom;
      s = 4'($urandom);
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      en = (en & ~m) | (w & m & 32'h556);
      apb(1'b1, CSR, w, s, 33'h0);
      apb(1'b0, CSR, 32'h0, 4'h0, {1'b0, 32'h02000000 | en});
    end
    apb(1'b1, CSR, 32'h0, 4'hF, 33'h0);
    // event pulses with parity response off: flag still sets, then one-write clears it
    for (i = 0; i < 3; i++) begin
      coreEvent[evIdx[i]] <= 1'b1;
      @(posedge clk_sys);
      coreEvent[evIdx[i]] <= 1'b0;
      apb(1'b0, CSR, 32'h0, 4'h0, {1'b0, 32'h02000000 | flagBit[i]});
      apb(1'b1, CSR, flagBit[i], 4'h8, 33'h0);
      apb(1'b0, CSR, 32'h0, 4'h0, {1'b0, 32'h02000000});
    end
    // all requests up with every enable clear
    {coreEvent.backEndIrq, coreEvent.systemFault, coreEvent.parityReport} <= 3'h7;
    {masterStartReq, writeInvalidateReq, memDecodeHit, ioDecodeHit, specialCycleHit} <= 5'h1F;
    linkRun <= 1'b1;
    repeat (60) @(posedge clk_sys);
    check("pins", 33'h80, {25'h0, pinVec});
    apb(1'b0, CSR, 32'h0, 4'h0, {1'b0, 32'h02080000});
    // every enable set; claim needs two link clock rises, hence the long wait
    apb(1'b1, CSR, 32'h556, 4'hF, 33'h0);
    repeat (60) @(posedge clk_sys);
    check("pins", 33'h7C, {25'h0, pinVec});
    // open-drain pins only ever pull low, so every output value stays 0 while driven
    check("pin out levels", 33'h0, {29'h0, parityFaultPinOut, systemFaultPinOut, interruptAPinOut, targetClaimPinOut});
    apb(1'b0, CSR, 32'h0, 4'h0, {1'b0, 32'h42080556});
    coreEvent.masterActive <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, CSR, 32'h0, 4'h0, {1'b0, 32'h43080556});
    {coreEvent.backEndIrq, coreEvent.systemFault, coreEvent.parityReport, coreEvent.masterActive} <= 4'h0;
    memDecodeHit <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check("pins", 33'h0C, {25'h0, pinVec});
    apb(1'b1, CSR, 32'h556, 4'hF, 33'h0);
    apb(1'b0, CSR, 32'h0, 4'h0, {1'b0, 32'h43000556});
    apb(1'b1, CSR, 32'hFFFFFFFF, 4'hF, 33'h0);
    apb(1'b0, CSR, 32'h0, 4'h0, {1'b0, 32'h02000556});
    // far side pulls the parity line low while this device is master
    coreEvent.masterActive <= 1'b1;
    reportParity <= 1'b1;
    repeat (60) @(posedge clk_sys);
    {coreEvent.masterActive, reportParity, linkRun} <= 3'h0;
    apb(1'b0, CSR, 32'h0, 4'h0, {1'b0, 32'h03000556});
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule : tb

bind pcs_cmd_status pcs_cmd_status_asserts i_pcs_cmd_status_asserts (.clk_sys, .sys_rst, .clkEn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .coreEvent, .masterStartReq, .masterStartGrant,
  .writeInvalidateAllowed, .ioClaim, .specialCycleClaim, .targetClaimPinOe, .interruptAPinOe,
  .systemFaultPinOe, .parityFaultPinOe);
